// ---- verilog/cop_watchdog_cfg.svh ----
/*
   Constants of the watchdog block: register offsets, field positions,
   reset values and cycle counts. Assumes a byte-addressed 32-bit
   Avalon-MM slave port in which every register takes one aligned word.
*/
// What this block does
// - counters run on the quad bus clock
// - stop instruction zeroes the prescale counter
// - service write clears watchdog and prescale bits 11..4
// - service register read returns reset vector low byte
// - power-on clears prescaler after 4096 cycles
// - internal reset clears both counters
// - disable signal follows config register one bit
// - 6-bit watchdog counter fed by prescaler carry
// - unserviced overflow resets after 262128 or 8176 cycles
// - reset drives pin low 32 cycles, sets flag
`ifndef COP_WATCHDOG_CFG_SVH
`define COP_WATCHDOG_CFG_SVH

`define WD_ADDR_W        5
`define WD_OFS_SERVICE   5'h00
`define WD_OFS_CONFIG_REGISTER_ONE   5'h04
`define WD_OFS_CAUSE     5'h08
`define WD_OFS_IRQ_ST    5'h0C
`define WD_OFS_IRQ_MASK  5'h10
`define WD_OFS_COUNT     5'h14

`define WD_PRE_W         12
`define WD_CNT_W         6
`define WD_TOTAL_W       18
`define WD_SVC_CLR_MASK  12'h00F

`define WD_CFG_DISABLE   0
`define WD_CFG_RATE      1
`define WD_CFG_PIN_EN    2
`define WD_CFG_W         3
`define WD_CFG_RESET     3'h4

`define WD_CAUSE_WDOG    0
`define WD_CAUSE_POR     1
`define WD_IRQ_TIMEOUT   0
`define WD_IRQ_SERVICE   1
`define WD_FLAG_W        2

`define WD_LONG_CYCLES   262128
`define WD_SHORT_CYCLES  8176
`define WD_POR_W         13
`define WD_POR_CYCLES    13'h1000
`define WD_PULSE_W       6
`define WD_PULSE_CYCLES  32
`define WD_VECTOR_LOW    8'h00

`endif

// ---- verilog/cop_watchdog_pkg.sv ----
/*
   Types of the watchdog block: bus request carrier and the packed
   state records of both modules. Assumes the constants header.
*/
`include "cop_watchdog_cfg.svh"

package cop_watchdog_pkg;

   typedef struct packed {
      logic [`WD_ADDR_W-1:0] address;
      logic                  read;
      logic                  write;
      logic [31:0]           writedata;
      logic [3:0]            byteenable;
   } bus_req_s;

   typedef struct packed {
      logic [`WD_PRE_W-1:0]  pre;
      logic [`WD_CNT_W-1:0]  wd;
      logic [`WD_POR_W-1:0]  por_cnt;
      logic                  por_busy;
      logic [`WD_CFG_W-1:0]  cfg;
      logic [`WD_FLAG_W-1:0] cause;
      logic [`WD_FLAG_W-1:0] irq_st;
      logic [`WD_FLAG_W-1:0] irq_mask;
      logic                  ack;
      logic [31:0]           rdata;
   } wdog_state_s;

   typedef struct packed {
      logic                  busy;
      logic                  pin_drive;
      logic [`WD_PULSE_W-1:0] cnt;
   } stretch_state_s;

endpackage

// ---- verilog/reset_stretch.sv ----
/*
   Stretches a one-cycle watchdog fire into a fixed-length reset pulse
   and drives the open-drain reset pin while enabled. Assumes fire
   pulses come from the same clock domain.
*/
`include "cop_watchdog_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module reset_stretch
#(
   parameter int PULSE_CYCLES = `WD_PULSE_CYCLES
)
(
   input  wire logic clk_in,        // quad bus clock
   input  wire logic srst_in,       // sync reset, high
   input  wire logic ce_in,         // clock enable
   input  wire logic fire_in,       // one-cycle overflow pulse
   input  wire logic pin_en_in,     // reset pin enable bit
   output var  logic busy_out,      // pulse in progress
   output var  logic rst_pin_o_out, // pin level when driven
   output var  logic rst_pin_oe_out // pin driven low
);

   cop_watchdog_pkg::stretch_state_s st_ff;
   cop_watchdog_pkg::stretch_state_s nxt_st;

   always_comb
   begin
      nxt_st = st_ff;
      if (fire_in && !st_ff.busy)
      begin
         nxt_st.busy      = 1'b1;
         nxt_st.pin_drive = pin_en_in;
         nxt_st.cnt       = `WD_PULSE_W'(PULSE_CYCLES - 1);
      end
      else if (st_ff.busy)
      begin
         if (st_ff.cnt == '0)
         begin
            nxt_st.busy      = 1'b0;
            nxt_st.pin_drive = 1'b0;
         end
         else
         begin
            nxt_st.cnt = st_ff.cnt - `WD_PULSE_W'(1);
         end
      end
   end

   always_ff @(posedge clk_in)
   begin
      if (srst_in)
      begin
         st_ff <= '0;
      end
      else if (ce_in)
      begin
         st_ff <= nxt_st;
      end
   end

   assign busy_out       = st_ff.busy;
   assign rst_pin_o_out  = 1'b0;
   assign rst_pin_oe_out = st_ff.pin_drive;

endmodule

`default_nettype wire

// ---- verilog/cop_watchdog_counter.sv ----
/*
   Watchdog: 12-bit prescale counter feeding a 6-bit watchdog counter,
   service register, configuration, reset cause and interrupt registers
   on an Avalon-MM slave with waitrequest. Assumes clk_in is the quad
   bus clock taken straight from the selected oscillator, and that the
   system reset logic answers watchdog_reset_out.
*/
`include "cop_watchdog_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module cop_watchdog_counter
#(
   parameter int        LONG_CYCLES  = `WD_LONG_CYCLES,
   parameter int        SHORT_CYCLES = `WD_SHORT_CYCLES,
   parameter int        PULSE_CYCLES = `WD_PULSE_CYCLES,
   parameter logic [7:0] VECTOR_LOW  = `WD_VECTOR_LOW // arbitrary value
)
(
   input  wire logic                  clk_in,               // quad bus clk
   input  wire logic                  srst_in,              // power-on rst
   input  wire logic                  ce_in,                // clock enable
   input  wire logic                  stop_in,              // stop executed
   input  wire logic                  int_reset_in,         // internal rst
   input  wire logic [`WD_ADDR_W-1:0] avs_address_in,       // byte address
   input  wire logic                  avs_read_in,          // read strobe
   input  wire logic                  avs_write_in,         // write strobe
   input  wire logic [31:0]           avs_writedata_in,     // write data
   input  wire logic [3:0]            avs_byteenable_in,    // byte lanes
   output var  logic [31:0]           avs_readdata_out,     // read data
   output var  logic                  avs_waitrequest_out,  // stall
   output var  logic                  watchdog_disable_out, // disable level
   output var  logic                  watchdog_reset_out,   // reset request
   output var  logic                  rst_pin_o_out,        // pin level
   output var  logic                  rst_pin_oe_out,       // pin drive
   output var  logic                  irq_out               // interrupt
);

   cop_watchdog_pkg::bus_req_s    req;
   cop_watchdog_pkg::wdog_state_s st_ff;
   cop_watchdog_pkg::wdog_state_s nxt_st;

   logic                    pulse_busy;
   logic                    fire;
   logic                    svc_wr;
   logic                    take;
   logic [`WD_TOTAL_W-1:0]  total;
   logic [`WD_TOTAL_W-1:0]  limit;
   logic [`WD_FLAG_W-1:0]   cause_clr;
   logic [`WD_FLAG_W-1:0]   irq_clr;
   logic [`WD_FLAG_W-1:0]   irq_set;
   logic [`WD_PRE_W:0]      pre_inc;

   // limit is the last count before overflow, so one cycle is spent on it
   function automatic logic [`WD_TOTAL_W-1:0] last_count(input int cyc);
      last_count = `WD_TOTAL_W'(cyc - 1);
   endfunction

   // the word-aligned low byte is all the data these registers hold
   function automatic logic lane0_wr(input cop_watchdog_pkg::bus_req_s r,
                                     input logic [`WD_ADDR_W-1:0] ofs);
      lane0_wr = r.write && r.byteenable[0] && (r.address == ofs);
   endfunction

   assign req.address    = avs_address_in;
   assign req.read       = avs_read_in;
   assign req.write      = avs_write_in;
   assign req.writedata  = avs_writedata_in;
   assign req.byteenable = avs_byteenable_in;

   // a request is taken only at the edge where waitrequest is low
   assign take   = ce_in && st_ff.ack && (req.read || req.write);
   assign avs_waitrequest_out = (req.read || req.write) && !st_ff.ack;

   // service counts for any data and any byte lane
   assign svc_wr = take && req.write && (req.address == `WD_OFS_SERVICE);

   assign total = {st_ff.wd, st_ff.pre};
   assign limit = st_ff.cfg[`WD_CFG_RATE] ? last_count(SHORT_CYCLES)
                                          : last_count(LONG_CYCLES);

   // overflow only while enabled and not held by power-on or service
   assign fire = (total == limit)
              && !st_ff.cfg[`WD_CFG_DISABLE]
              && !st_ff.por_busy
              && !int_reset_in
              && !svc_wr
              && !pulse_busy;

   assign pre_inc = {1'b0, st_ff.pre} + (`WD_PRE_W+1)'(1);

   always_comb
   begin
      cause_clr = '0;
      irq_clr   = '0;
      irq_set   = '0;
      if (take && lane0_wr(req, `WD_OFS_CAUSE))
      begin
         cause_clr = req.writedata[`WD_FLAG_W-1:0];
      end
      if (take && lane0_wr(req, `WD_OFS_IRQ_ST))
      begin
         irq_clr = req.writedata[`WD_FLAG_W-1:0];
      end
      irq_set[`WD_IRQ_TIMEOUT] = fire;
      irq_set[`WD_IRQ_SERVICE] = svc_wr;
   end

   always_comb
   begin
      nxt_st = st_ff;

      // counter chain: prescaler carry steps the watchdog counter
      nxt_st.pre = pre_inc[`WD_PRE_W-1:0];
      if (pre_inc[`WD_PRE_W])
      begin
         nxt_st.wd = st_ff.wd + `WD_CNT_W'(1);
      end

      if (stop_in)
      begin
         nxt_st.pre = '0;
      end

      if (svc_wr)
      begin
         nxt_st.wd  = '0;
         nxt_st.pre = nxt_st.pre & `WD_SVC_CLR_MASK;
      end

      if (fire)
      begin
         // counters restart so the pulse is not re-triggered
         nxt_st.wd  = '0;
         nxt_st.pre = '0;
      end

      // power-on hold: prescaler kept clear until the count completes
      if (st_ff.por_busy)
      begin
         nxt_st.pre = '0;
         nxt_st.wd  = '0;
         if (st_ff.por_cnt == `WD_POR_CYCLES - `WD_POR_W'(1))
         begin
            nxt_st.por_busy = 1'b0;
         end
         else
         begin
            nxt_st.por_cnt = st_ff.por_cnt + `WD_POR_W'(1);
         end
      end

      if (int_reset_in)
      begin
         nxt_st.pre = '0;
         nxt_st.wd  = '0;
      end

      // configuration register one
      if (take && lane0_wr(req, `WD_OFS_CONFIG_REGISTER_ONE))
      begin
         nxt_st.cfg = req.writedata[`WD_CFG_W-1:0];
      end

      if (take && lane0_wr(req, `WD_OFS_IRQ_MASK))
      begin
         nxt_st.irq_mask = req.writedata[`WD_FLAG_W-1:0];
      end

      // sticky flags: a set in the clearing cycle wins
      nxt_st.cause = st_ff.cause & ~cause_clr;
      if (fire)
      begin
         nxt_st.cause[`WD_CAUSE_WDOG] = 1'b1;
      end
      nxt_st.irq_st = (st_ff.irq_st & ~irq_clr) | irq_set;

      // bus answer: one wait cycle, then data from the flops
      if ((req.read || req.write) && !st_ff.ack)
      begin
         nxt_st.ack   = 1'b1;
         nxt_st.rdata = '0;
         if (req.read)
         begin
            if (req.address == `WD_OFS_SERVICE)
            begin
               nxt_st.rdata = {24'h000000, VECTOR_LOW};
            end
            else if (req.address == `WD_OFS_CONFIG_REGISTER_ONE)
            begin
               nxt_st.rdata = {29'h00000000, st_ff.cfg};
            end
            else if (req.address == `WD_OFS_CAUSE)
            begin
               nxt_st.rdata = {30'h00000000, st_ff.cause};
            end
            else if (req.address == `WD_OFS_IRQ_ST)
            begin
               nxt_st.rdata = {30'h00000000, st_ff.irq_st};
            end
            else if (req.address == `WD_OFS_IRQ_MASK)
            begin
               nxt_st.rdata = {30'h00000000, st_ff.irq_mask};
            end
            else if (req.address == `WD_OFS_COUNT)
            begin
               nxt_st.rdata = {14'h0000, total};
            end
            else
            begin
               nxt_st.rdata = '0;
            end
         end
      end
      else
      begin
         nxt_st.ack = 1'b0;
      end
   end

   always_ff @(posedge clk_in)
   begin
      if (srst_in)
      begin
         st_ff                        <= '0;
         st_ff.por_busy               <= 1'b1;
         st_ff.cfg                    <= `WD_CFG_RESET;
         st_ff.cause[`WD_CAUSE_POR]   <= 1'b1;
      end
      else if (ce_in)
      begin
         st_ff <= nxt_st;
      end
   end

   reset_stretch
   #(
      .PULSE_CYCLES (PULSE_CYCLES)
   )
   u_stretch
   (
      .clk_in         (clk_in),
      .srst_in        (srst_in),
      .ce_in          (ce_in),
      .fire_in        (fire),
      .pin_en_in      (st_ff.cfg[`WD_CFG_PIN_EN]),
      .busy_out       (pulse_busy),
      .rst_pin_o_out  (rst_pin_o_out),
      .rst_pin_oe_out (rst_pin_oe_out)
   );

   assign watchdog_reset_out   = pulse_busy;
   assign watchdog_disable_out = st_ff.cfg[`WD_CFG_DISABLE];
   assign avs_readdata_out     = st_ff.rdata;
   assign irq_out              = |(st_ff.irq_st & st_ff.irq_mask);

endmodule

`default_nettype wire

// ---- tb/wdog_partner.sv ----
/*
   System reset logic and reset pin pull-up facing the watchdog.
   Assumes the watchdog's reset request is a registered level.
*/
`timescale 1ns/1ps
`default_nettype none
module wdog_partner
(
   input  wire logic wd_reset_in,   // watchdog reset request
   input  wire logic pin_o_in,      // pin level when driven
   input  wire logic pin_oe_in,     // pin driven
   output var  logic int_reset_out, // internal reset back
   output var  logic pin_out        // resolved pin level
);
   // pull-up wins whenever nobody drives the pin
   assign pin_out = pin_oe_in ? pin_o_in : 1'b1;
   // system holds the internal reset while the request stands
   assign int_reset_out = wd_reset_in;
endmodule
`default_nettype wire

// ---- tb/cop_watchdog_counter_sva.sv ----
/*
   Port-level checker of the watchdog, bound into its top module.
   Assumes one clock domain with synchronous active-high reset.
*/
`include "cop_watchdog_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module cop_watchdog_counter_chk
#(
   parameter int         LONG_CYCLES  = 262128,
   parameter int         SHORT_CYCLES = 8176,
   parameter int         PULSE_CYCLES = 32,
   parameter logic [7:0] VECTOR_LOW   = 8'h00
)
(
   input wire logic                  clk_in,               // clock
   input wire logic                  srst_in,              // reset
   input wire logic                  ce_in,                // enable
   input wire logic                  stop_in,              // stop
   input wire logic                  int_reset_in,         // int reset
   input wire logic [`WD_ADDR_W-1:0] avs_address_in,       // address
   input wire logic                  avs_read_in,          // read
   input wire logic                  avs_write_in,         // write
   input wire logic [31:0]           avs_writedata_in,     // wdata
   input wire logic [3:0]            avs_byteenable_in,    // lanes
   input wire logic [31:0]           avs_readdata_out,     // rdata
   input wire logic                  avs_waitrequest_out,  // stall
   input wire logic                  watchdog_disable_out, // disable
   input wire logic                  watchdog_reset_out,   // reset req
   input wire logic                  rst_pin_o_out,        // pin level
   input wire logic                  rst_pin_oe_out,       // pin drive
   input wire logic                  irq_out               // interrupt
);
   logic [6:0]  hi_ff;
   logic [19:0] since_ff;
   logic        svc_take;
   assign svc_take = avs_write_in && !avs_waitrequest_out && ce_in &&
                     avs_address_in == `WD_OFS_SERVICE;
   // since_ff only gives a lower bound: stop may delay overflow
   always_ff @(posedge clk_in)
   begin
      if (srst_in)
      begin
         hi_ff    <= 7'h00;
         since_ff <= 20'h00000;
      end
      else
      begin
         hi_ff    <= watchdog_reset_out ? hi_ff + 7'h01 : 7'h00;
         since_ff <= (svc_take || int_reset_in || watchdog_reset_out) ?
                     20'h00000 : since_ff + 20'h00001;
      end
   end
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (srst_in);
   property p_svc_read;
      avs_read_in && !avs_waitrequest_out &&
      avs_address_in == `WD_OFS_SERVICE |->
      avs_readdata_out == {24'h000000, VECTOR_LOW};
   endproperty
   a_svc_read: assert property (p_svc_read)
      else $error("service read data wrong");
   property p_cfg;
      avs_write_in && !avs_waitrequest_out && ce_in &&
      avs_address_in == `WD_OFS_CONFIG_REGISTER_ONE |=>
      watchdog_disable_out == $past(avs_writedata_in[`WD_CFG_DISABLE]);
   endproperty
   a_cfg: assert property (p_cfg)
      else $error("disable output does not follow config");
   property p_no_fire_dis;
      $rose(watchdog_reset_out) |-> !$past(watchdog_disable_out);
   endproperty
   a_no_fire_dis: assert property (p_no_fire_dis)
      else $error("reset while disabled");
   property p_no_fire_int;
      $rose(watchdog_reset_out) |-> !$past(int_reset_in);
   endproperty
   a_no_fire_int: assert property (p_no_fire_int)
      else $error("reset during internal reset");
   property p_pulse_len;
      $fell(watchdog_reset_out) && !$past(srst_in) |->
      hi_ff == PULSE_CYCLES;
   endproperty
   a_pulse_len: assert property (p_pulse_len)
      else $error("reset pulse length wrong");
   property p_oe_pulse;
      rst_pin_oe_out |-> watchdog_reset_out && !rst_pin_o_out;
   endproperty
   a_oe_pulse: assert property (p_oe_pulse)
      else $error("pin driven outside pulse");
   property p_min_gap;
      $rose(watchdog_reset_out) |-> since_ff >= SHORT_CYCLES - 17;
   endproperty
   a_min_gap: assert property (p_min_gap)
      else $error("overflow too early");
   property p_one_wait;
      (avs_read_in || avs_write_in) && avs_waitrequest_out && ce_in |=>
      !avs_waitrequest_out;
   endproperty
   a_one_wait: assert property (p_one_wait)
      else $error("bus answer late");
   c_fire: cover property ($rose(watchdog_reset_out));
   c_pin: cover property ($rose(rst_pin_oe_out));
   c_svc: cover property (svc_take);
endmodule
bind cop_watchdog_counter cop_watchdog_counter_chk #(
   .LONG_CYCLES(LONG_CYCLES), .SHORT_CYCLES(SHORT_CYCLES),
   .PULSE_CYCLES(PULSE_CYCLES), .VECTOR_LOW(VECTOR_LOW)) u_chk (
   .clk_in(clk_in), .srst_in(srst_in), .ce_in(ce_in), .stop_in(stop_in),
   .int_reset_in(int_reset_in), .avs_address_in(avs_address_in),
   .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
   .avs_writedata_in(avs_writedata_in),
   .avs_byteenable_in(avs_byteenable_in),
   .avs_readdata_out(avs_readdata_out),
   .avs_waitrequest_out(avs_waitrequest_out),
   .watchdog_disable_out(watchdog_disable_out),
   .watchdog_reset_out(watchdog_reset_out), .rst_pin_o_out(rst_pin_o_out),
   .rst_pin_oe_out(rst_pin_oe_out), .irq_out(irq_out));
`default_nettype wire

// ---- tb/tb_top.sv ----
/*
   Self-checking bench of the watchdog: bus tasks, read-data queue and
   scenario sequence. Assumes the partner model and the bound checker.
*/
`include "cop_watchdog_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   localparam int LONG  = 300;
   localparam int SHORT = 40;
   logic                  clk_in            = 1'b0;
   logic                  srst_in           = 1'b1;
   logic                  stop_in           = 1'b0;
   logic                  tb_int_rst        = 1'b0;
   logic [`WD_ADDR_W-1:0] avs_address_in    = '0;
   logic                  avs_read_in       = 1'b0;
   logic                  avs_write_in      = 1'b0;
   logic [31:0]           avs_writedata_in  = '0;
   logic [3:0]            avs_byteenable_in = 4'hF;
   logic                  fired             = 1'b0;
   wire logic [31:0]      avs_readdata_out;
   wire logic             avs_waitrequest_out, watchdog_disable_out;
   wire logic             watchdog_reset_out, rst_pin_o_out;
   wire logic             rst_pin_oe_out, irq_out, part_rst, pin;
   logic [31:0]           exp_q[$];
   logic [31:0]           msk_q[$];
   int                    n_errors  = 0;
   int                    cmp_count = 0;
   int                    seed      = 32'hd2a9;
   int                    n;
   cop_watchdog_counter #(.LONG_CYCLES(LONG), .SHORT_CYCLES(SHORT)) u_dut (
      .clk_in(clk_in), .srst_in(srst_in), .ce_in(1'b1), .stop_in(stop_in),
      .int_reset_in(part_rst | tb_int_rst),
      .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
      .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
      .avs_byteenable_in(avs_byteenable_in),
      .avs_readdata_out(avs_readdata_out),
      .avs_waitrequest_out(avs_waitrequest_out),
      .watchdog_disable_out(watchdog_disable_out),
      .watchdog_reset_out(watchdog_reset_out),
      .rst_pin_o_out(rst_pin_o_out), .rst_pin_oe_out(rst_pin_oe_out),
      .irq_out(irq_out));
   wdog_partner u_part (.wd_reset_in(watchdog_reset_out),
      .pin_o_in(rst_pin_o_out), .pin_oe_in(rst_pin_oe_out),
      .int_reset_out(part_rst), .pin_out(pin));
   initial forever #25 clk_in = ~clk_in;
   task automatic summarize;
      $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      cmp_count++;
      if (g !== e)
      begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   // reads note expected data and mask; the monitor compares
   task automatic bus(input logic wr, input logic [4:0] a,
                      input logic [31:0] d, input logic [31:0] e,
                      input logic [31:0] m);
      @(posedge clk_in);
      avs_address_in    <= a;
      avs_write_in      <= wr;
      avs_read_in       <= !wr;
      avs_writedata_in  <= d;
      avs_byteenable_in <= (a == 5'h00) ? 4'($random(seed)) : 4'hF;
      if (!wr)
      begin
         exp_q.push_back(e);
         msk_q.push_back(m);
      end
      @(posedge clk_in iff !avs_waitrequest_out);
      avs_read_in  <= 1'b0;
      avs_write_in <= 1'b0;
   endtask
   task automatic wait_fire(output int c);
      c = 0;
      while (watchdog_reset_out !== 1'b1 && c < 2000)
      begin
         @(negedge clk_in);
         c++;
      end
   endtask
   always @(posedge clk_in)
   begin
      if (watchdog_reset_out === 1'b1)
         fired <= 1'b1;
      if (avs_read_in && avs_waitrequest_out === 1'b0)
         chk("readdata", exp_q.pop_front(),
             avs_readdata_out & msk_q.pop_front());
   end
   initial
   begin
      #(20000 * 50);
      n_errors++;
      summarize();
   end
   initial
   begin
      repeat (10) @(posedge clk_in);
      srst_in <= 1'b0;
      bus(0, `WD_OFS_SERVICE, 0, {24'h0, `WD_VECTOR_LOW}, '1);
      bus(0, `WD_OFS_CONFIG_REGISTER_ONE, 0, 32'h4, '1);
      bus(0, `WD_OFS_COUNT, 0, 32'h0, '1);
      bus(0, 5'h1C, 0, 32'h0, '1);
      bus(1, `WD_OFS_CONFIG_REGISTER_ONE, 32'h5, 0, 0);
      @(negedge clk_in);
      chk("disable", 1, watchdog_disable_out);
      repeat (4096 + LONG + 50) @(posedge clk_in);
      chk("no fire", 0, fired);
      bus(1, `WD_OFS_IRQ_MASK, 32'h1, 0, 0);
      bus(1, `WD_OFS_CONFIG_REGISTER_ONE, 32'h6, 0, 0);
      bus(1, `WD_OFS_SERVICE, $random(seed), 0, 0);
      bus(0, `WD_OFS_COUNT, 0, 0, 32'hFFFF_FFE0);
      @(negedge clk_in);
      chk("irq masked", 0, irq_out);
      stop_in <= 1'b1;
      @(posedge clk_in);
      stop_in <= 1'b0;
      bus(0, `WD_OFS_COUNT, 0, 0, 32'h0000_0FE0);
      tb_int_rst <= 1'b1;
      @(posedge clk_in);
      tb_int_rst <= 1'b0;
      bus(0, `WD_OFS_COUNT, 0, 0, 32'hFFFF_FFE0);
      bus(1, `WD_OFS_SERVICE, $random(seed), 0, 0);
      wait_fire(n);
      chk("short gap", 1, 32'(n >= SHORT - 17 && n <= SHORT + 2));
      chk("pin low", 0, pin);
      bus(1, `WD_OFS_CONFIG_REGISTER_ONE, 32'h1, 0, 0);
      bus(0, `WD_OFS_CAUSE, 0, 32'h1, 32'h1);
      @(negedge clk_in);
      chk("irq set", 1, irq_out);
      bus(1, `WD_OFS_IRQ_ST, 32'h3, 0, 0);
      @(negedge clk_in);
      chk("irq clear", 0, irq_out);
      bus(1, `WD_OFS_CONFIG_REGISTER_ONE, 32'h0, 0, 0);
      // counters stay clear until the first pulse has ended
      @(negedge clk_in iff watchdog_reset_out === 1'b0);
      bus(1, `WD_OFS_SERVICE, $random(seed), 0, 0);
      wait_fire(n);
      chk("long gap", 1, 32'(n >= LONG - 17 && n <= LONG + 2));
      chk("pin idle", 1, pin);
      repeat (40) @(posedge clk_in);
      summarize();
   end
endmodule
`default_nettype wire
